// File: verilog/spi_fram_command_core.sv
// Purpose: Command core of a 32K x 8 serial memory acting as an SPI slave.
// Assumes: CS_N, SCK, SI and WP_N are asynchronous pins, sampled on CLK.
// Notes:   SCK must stay well below CLK / 4 so that every edge is seen.
//
// Operation
// - Opcodes set and clear the write latch.
// - Latch clear disables writes; status shows zero.
// - Status read shifts out the status byte.
// - Recognise read, fast read and write opcodes.
// - Exactly nine opcodes, including sleep and identification.
// - Write latch clear after power-up.
// - Status write cannot alter the latch flag.
// - Latch clears at frame end of writes.
// - Status layout; unused bits read zero.
// - Busy bit zero except while waking.
// - Block guard bits kept nonvolatile, factory zero.
// - Guard bits select protected address range.
// - Clear latch blocks all; else guarded range.
// - Pin blocks status write only when enabled.
// - Protect pin never blocks array writes.
// - Write frame: opcode, two address bytes, data.
// - Address advances per byte, wraps to zero.
// - Byte committed after eighth bit, MSB first.
// - Guarded address stops burst, discards rest.
// - Chip select rise ends memory write.
// - Read data driven MSB first, SI ignored.
// - Invalid opcode ignored, output stays off.
// - Sample SI rising, change SO falling.
// - Clock level at select picks mode.
// - Deselected: SI ignored, SO released.

module spi_fram_command_core
   import fram_pkg::*;
(
   input  wire logic CLK,
   input  wire logic SRST,
   input  wire logic CS_N,
   input  wire logic SCK,
   input  wire logic SI,
   input  wire logic WP_N,
   output logic      SO,
   output logic      SO_OE_N
);

   // ----------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------------
   pins_t meta;
   pins_t pins;
   pins_t prev;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         meta <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
         pins <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
         prev <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
      end else begin
         meta <= '{cs_n: CS_N, sck: SCK, si: SI, wp_n: WP_N};
         pins <= meta;
         prev <= pins;
      end
   end

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   state_t      state,      next_state;
   logic [2:0]  bit_cnt,    next_bit_cnt;
   logic [2:0]  out_cnt,    next_out_cnt;
   logic [7:0]  in_shift,   next_in_shift;
   logic [7:0]  out_shift,  next_out_shift;
   logic [7:0]  cmd,        next_cmd;
   logic [14:0] addr,       next_addr;
   logic        addr_hi,    next_addr_hi;
   logic        write_latch_flag,        next_wel;
   logic        pin_guard,  next_pin_guard;
   logic [1:0]  guard,      next_guard;
   logic        end_clears, next_end_clears;
   logic        sleep_pend, next_sleep_pend;
   logic        asleep,     next_asleep;
   logic [3:0]  wake_cnt,   next_wake_cnt;
   logic        halted,     next_halted;
   logic        mode3,      next_mode3;
   logic        seen_fall,  next_seen_fall;
   logic        next_so;
   logic        next_so_oe_n;

   logic        cs_fall;
   logic        cs_rise;
   logic        sck_rise;
   logic        sck_fall;
   logic        in_state;
   logic        out_state;
   logic        byte_done;
   logic [7:0]  in_byte;
   logic [7:0]  status;
   logic [7:0]  out_src;
   logic [7:0]  mem_rdata;
   logic        mem_we;
   logic        wel_event;
   logic [2:0]  guard_bits;

   // In mode 3 the clock idles high, so a rising edge only counts once the
   // clock has first fallen inside the frame.
   assign cs_fall   = prev.cs_n & ~pins.cs_n;
   assign cs_rise   = ~prev.cs_n & pins.cs_n;
   assign sck_rise  = ~prev.sck & pins.sck & ~pins.cs_n & (~mode3 | seen_fall);
   assign sck_fall  = prev.sck & ~pins.sck & ~pins.cs_n;
   assign in_state  = (state == S_OPCODE) || (state == S_ADDR) || (state == S_DUMMY) ||
                      (state == S_STAT_IN) || (state == S_WRITE);
   assign out_state = (state == S_READ) || (state == S_STAT_OUT) || (state == S_ID_OUT);
   assign in_byte   = {in_shift[6:0], pins.si};
   assign byte_done = sck_rise && (bit_cnt == 3'd7) && in_state;
   assign status    = {pin_guard, 3'b000, guard, write_latch_flag, (wake_cnt != 4'd0)};
   assign out_src   = (state == S_READ) ? mem_rdata :
                      (state == S_STAT_OUT) ? status : ID_FILL;
   assign wel_event  = cs_rise || (byte_done && (state == S_OPCODE));
   assign guard_bits = {pin_guard, guard};

   fram_array u_array (
      .clk   (CLK),
      .we    (mem_we),
      .addr  (addr),
      .wdata (in_byte),
      .rdata (mem_rdata)
   );

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_out_cnt    = out_cnt;
      next_in_shift   = in_shift;
      next_out_shift  = out_shift;
      next_cmd        = cmd;
      next_addr       = addr;
      next_addr_hi    = addr_hi;
      next_wel        = write_latch_flag;
      next_pin_guard  = pin_guard;
      next_guard      = guard;
      next_end_clears = end_clears;
      next_sleep_pend = sleep_pend;
      next_asleep     = asleep;
      next_wake_cnt   = (wake_cnt != 4'd0) ? wake_cnt - 4'd1 : wake_cnt;
      next_halted     = halted;
      next_mode3      = mode3;
      next_seen_fall  = seen_fall;
      next_so         = SO;
      next_so_oe_n    = SO_OE_N;
      mem_we          = 1'b0;
      if (cs_rise) begin
         // A frame ends here: writes close and the output lets go of SO.
         next_state      = S_IDLE;
         next_so_oe_n    = 1'b1;
         next_end_clears = 1'b0;
         next_sleep_pend = 1'b0;
         if (end_clears) begin
            next_wel = 1'b0;
         end
         if (sleep_pend) begin
            next_asleep = 1'b1;
         end
      end else if (cs_fall) begin
         next_bit_cnt   = 3'd0;
         next_mode3     = pins.sck;
         next_seen_fall = 1'b0;
         next_halted    = 1'b0;
         next_addr_hi   = 1'b1;
         if (asleep) begin
            next_asleep   = 1'b0;
            next_wake_cnt = WAKE_LOAD;
            next_state    = S_SINK;
         end else if (wake_cnt != 4'd0) begin
            next_state = S_SINK;
         end else begin
            next_state = S_OPCODE;
         end
      end else if (state != S_IDLE) begin
         if (sck_fall) begin
            next_seen_fall = 1'b1;
         end
         if (sck_rise) begin
            next_bit_cnt  = bit_cnt + 3'd1;
            next_in_shift = in_byte;
         end
         if (byte_done) begin
            case (state)
               S_OPCODE: begin
                  next_cmd = in_byte;
                  case (in_byte)
                     OP_LATCH_SET: begin
                        next_wel   = 1'b1;
                        next_state = S_SINK;
                     end
                     OP_LATCH_CLEAR: begin
                        next_wel        = 1'b0;
                        next_end_clears = 1'b1;
                        next_state      = S_SINK;
                     end
                     OP_STATUS_READ: begin
                        next_out_cnt = 3'd0;
                        next_state   = S_STAT_OUT;
                     end
                     OP_STATUS_WRITE: begin
                        next_end_clears = 1'b1;
                        next_state      = S_STAT_IN;
                     end
                     OP_READ, OP_FAST_READ, OP_WRITE: begin
                        next_end_clears = (in_byte == OP_WRITE);
                        next_state      = S_ADDR;
                     end
                     OP_SLEEP: begin
                        next_sleep_pend = 1'b1;
                        next_state      = S_SINK;
                     end
                     OP_ID_READ: begin
                        next_out_cnt = 3'd0;
                        next_state   = S_ID_OUT;
                     end
                     default: begin
                        next_state = S_SINK;
                     end
                  endcase
               end
               S_ADDR: begin
                  // The top address bit is dropped; only 15 bits index the array.
                  if (addr_hi) begin
                     next_addr    = {in_byte[6:0], addr[7:0]};
                     next_addr_hi = 1'b0;
                  end else begin
                     next_addr    = {addr[14:8], in_byte};
                     next_out_cnt = 3'd0;
                     if (cmd == OP_WRITE) begin
                        next_state = S_WRITE;
                     end else if (cmd == OP_FAST_READ) begin
                        next_state = S_DUMMY;
                     end else begin
                        next_state = S_READ;
                     end
                  end
               end
               S_DUMMY: begin
                  next_out_cnt = 3'd0;
                  next_state   = S_READ;
               end
               S_STAT_IN: begin
                  // The latch flag is not taken from the written byte.
                  if (write_latch_flag && !(pin_guard && !pins.wp_n)) begin
                     next_pin_guard = in_byte[ST_PIN_GUARD];
                     next_guard     = in_byte[ST_GUARD_HI:ST_GUARD_LO];
                  end
                  next_state = S_SINK;
               end
               S_WRITE: begin
                  // The protect pin plays no part in array writes.
                  if (write_latch_flag && !halted && !guarded(guard, addr)) begin
                     mem_we    = 1'b1;
                     next_addr = addr + 15'd1;
                  end else begin
                     next_halted = 1'b1;
                  end
               end
               default: begin
                  next_state = state;
               end
            endcase
         end
         if (sck_fall && out_state) begin
            next_out_cnt = out_cnt + 3'd1;
            if (out_cnt == 3'd0) begin
               next_so        = out_src[7];
               next_out_shift = {out_src[6:0], 1'b0};
               next_so_oe_n   = 1'b0;
               if (state == S_READ) begin
                  next_addr = addr + 15'd1;
               end
            end else begin
               next_so        = out_shift[7];
               next_out_shift = {out_shift[6:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------------
   // Reset stands for first power-up, so the guard bits take their factory
   // value here and are otherwise only changed by an accepted status write.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state      <= S_IDLE;
         bit_cnt    <= 3'd0;
         out_cnt    <= 3'd0;
         in_shift   <= 8'h00;
         out_shift  <= 8'h00;
         cmd        <= 8'h00;
         addr       <= 15'h0000;
         addr_hi    <= 1'b1;
         write_latch_flag        <= STATUS_RESET[ST_WRITE_LATCH];
         pin_guard  <= STATUS_RESET[ST_PIN_GUARD];
         guard      <= STATUS_RESET[ST_GUARD_HI:ST_GUARD_LO];
         end_clears <= 1'b0;
         sleep_pend <= 1'b0;
         asleep     <= 1'b0;
         wake_cnt   <= 4'd0;
         halted     <= 1'b0;
         mode3      <= 1'b0;
         seen_fall  <= 1'b0;
         SO         <= 1'b0;
         SO_OE_N    <= 1'b1;
      end else begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         out_cnt    <= next_out_cnt;
         in_shift   <= next_in_shift;
         out_shift  <= next_out_shift;
         cmd        <= next_cmd;
         addr       <= next_addr;
         addr_hi    <= next_addr_hi;
         write_latch_flag        <= next_wel;
         pin_guard  <= next_pin_guard;
         guard      <= next_guard;
         end_clears <= next_end_clears;
         sleep_pend <= next_sleep_pend;
         asleep     <= next_asleep;
         wake_cnt   <= next_wake_cnt;
         halted     <= next_halted;
         mode3      <= next_mode3;
         seen_fall  <= next_seen_fall;
         SO         <= next_so;
         SO_OE_N    <= next_so_oe_n;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   latch_set_a: assert property (
      byte_done && (state == S_OPCODE) && (in_byte == OP_LATCH_SET) |=> write_latch_flag
   ) else $error("Latch set opcode did not set the write latch.");

   latch_clear_a: assert property (
      byte_done && (state == S_OPCODE) && (in_byte == OP_LATCH_CLEAR) |=> !write_latch_flag && !status[1]
   ) else $error("Latch clear opcode left the write latch set.");

   power_up_a: assert property (@(posedge CLK) disable iff (1'b0)
      SRST |=> !write_latch_flag && SO_OE_N
   ) else $error("Write latch or output enable wrong after reset.");

   latch_only_cmd_a: assert property (
      $changed(write_latch_flag) |-> $past(wel_event)
   ) else $error("Write latch changed without a latch command or frame end.");

   frame_end_clear_a: assert property (
      cs_rise && end_clears |=> !write_latch_flag
   ) else $error("Write latch survived the end of a write frame.");

   pin_guard_hold_a: assert property (
      byte_done && (state == S_STAT_IN) && pin_guard && !pins.wp_n |=> $stable(guard_bits)
   ) else $error("Status write accepted while the protect pin guarded it.");

   array_guard_a: assert property (
      mem_we |-> write_latch_flag && !guarded(guard, addr) && !halted
   ) else $error("Array write to a protected or disabled address.");

   addr_wrap_a: assert property (
      mem_we && (addr == ADDR_LAST) |=> (addr == 15'h0000)
   ) else $error("Write address did not wrap to zero.");

   bad_opcode_a: assert property (
      byte_done && (state == S_OPCODE) && !valid_op(in_byte) |=> (state == S_SINK) && SO_OE_N
   ) else $error("Invalid opcode was not ignored.");

   deselect_hiz_a: assert property (
      pins.cs_n ##1 pins.cs_n |-> SO_OE_N && (state == S_IDLE)
   ) else $error("Output driven while deselected.");

endmodule // spi_fram_command_core

// File: verilog/fram_pkg.sv
// Purpose: Shared constants, types and decoders for the serial memory command core.
// Assumes: System clock CLK at 25 MHz; the serial pins are asynchronous to it.
// Notes:   Every opcode, status field and guard boundary is named once here.

package fram_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int          CLK_NS      = 40;
   localparam int          WAKE_NS     = 400;
   localparam int          WAKE_CYCLES = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0]  WAKE_LOAD   = 4'(WAKE_CYCLES);

   // ----------------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------------
   localparam logic [7:0]  OP_LATCH_SET    = 8'h06;
   localparam logic [7:0]  OP_LATCH_CLEAR  = 8'h04;
   localparam logic [7:0]  OP_STATUS_READ  = 8'h05;
   localparam logic [7:0]  OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0]  OP_READ         = 8'h03;
   localparam logic [7:0]  OP_FAST_READ    = 8'h0B;
   localparam logic [7:0]  OP_WRITE        = 8'h02;
   localparam logic [7:0]  OP_SLEEP        = 8'hB9;
   localparam logic [7:0]  OP_ID_READ      = 8'h9F;

   // ----------------------------------------------------------------------
   // Status register layout and array geometry
   // ----------------------------------------------------------------------
   localparam int          ST_PIN_GUARD    = 7;
   localparam int          ST_GUARD_HI     = 3;
   localparam int          ST_GUARD_LO     = 2;
   localparam int          ST_WRITE_LATCH  = 1;
   localparam int          ST_BUSY         = 0;
   localparam logic [7:0]  STATUS_RESET    = 8'h00;
   localparam int          ADDR_W          = 15;
   localparam int          MEM_DEPTH       = 32768;
   localparam logic [14:0] ADDR_LAST       = 15'h7FFF;
   localparam logic [14:0] GUARD_QUARTER   = 15'h6000;
   localparam logic [14:0] GUARD_HALF      = 15'h4000;
   // Value is arbitrary; identification read repeats this byte.
   localparam logic [7:0]  ID_FILL         = 8'h5A;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE     = 4'b0000,
      S_OPCODE   = 4'b0001,
      S_ADDR     = 4'b0010,
      S_DUMMY    = 4'b0011,
      S_READ     = 4'b0100,
      S_WRITE    = 4'b0101,
      S_STAT_OUT = 4'b0110,
      S_STAT_IN  = 4'b0111,
      S_ID_OUT   = 4'b1000,
      S_SINK     = 4'b1001
   } state_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic wp_n;
   } pins_t;

   // ----------------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------------
   function automatic logic guarded(input logic [1:0] bp, input logic [14:0] a);
      case (bp)
         2'b01:   guarded = (a >= GUARD_QUARTER);
         2'b10:   guarded = (a >= GUARD_HALF);
         2'b11:   guarded = 1'b1;
         default: guarded = 1'b0;
      endcase
   endfunction

   function automatic logic valid_op(input logic [7:0] op);
      valid_op = (op == OP_LATCH_SET) || (op == OP_LATCH_CLEAR) ||
                 (op == OP_STATUS_READ) || (op == OP_STATUS_WRITE) ||
                 (op == OP_READ) || (op == OP_FAST_READ) || (op == OP_WRITE) ||
                 (op == OP_SLEEP) || (op == OP_ID_READ);
   endfunction

endpackage

// File: verilog/fram_array.sv
// Purpose: Byte-wide storage array of the serial memory, one write port and
//          an asynchronous read port sharing one index.
// Assumes: Writes arrive one byte per strobe from the command core.
// Notes:   No reset: the contents model nonvolatile cells.

module fram_array
   import fram_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   output logic      [7:0]        rdata
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [7:0] cells [MEM_DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         cells[addr] <= wdata;
      end
   end

   assign rdata = cells[addr];

endmodule // fram_array

// File: tb/spi_master_model.sv
// Purpose: Behavioural SPI master that drives chip select, clock and data in.
// Assumes: Half period of four CLK cycles, a link clock period of 320 ns.
// Notes:   The clock stands still outside frames; data in is inverted after each frame.

module spi_master_model (
   input  wire logic clk,
   input  wire logic so,
   input  wire logic so_oe_n,
   output logic      cs_n,
   output logic      sck,
   output logic      si
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cs_n = 1'h1;
      sck  = 1'h0;
      si   = 1'h0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // -------------------------------------------------------------------------
   // One chip-select frame, MSB first, reply sampled while the clock is high.
   // -------------------------------------------------------------------------
   task automatic frame(input logic m3, input logic [39:0] bits, input int nb,
                        output logic [7:0] rx, output logic drove);
      drove = 1'h0;
      rx    = 8'h00;
      sck <= m3;
      wait_clk(4);
      cs_n <= 1'h0;
      wait_clk(4);
      sck <= 1'h0;
      wait_clk(4);
      for (int i = 0; i < nb; i++) begin
         si <= bits[39-i];
         wait_clk(4);
         sck <= 1'h1;
         wait_clk(2);
         // A released output reads as the inverse of its last value, so stale data shows.
         #1 rx = {rx[6:0], so_oe_n ? ~so : so};
         drove = drove | !so_oe_n;
         wait_clk(2);
         sck <= 1'h0;
      end
      wait_clk(4);
      sck <= m3;
      wait_clk(4);
      // Data in goes to the inverse of its last value so a stale bit is never trusted.
      cs_n <= 1'h1;
      si   <= ~si;
      wait_clk(8);
   endtask
endmodule // spi_master_model

// File: tb/testbench.sv
// Purpose: Self-checking bench for the serial memory command core.
// Assumes: Array contents start unknown, so every read follows a write.
// Notes:   Each row is one frame; the latch is set in a frame of its own.

module testbench
   import fram_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic        wp;
      logic [39:0] bits;
      logic [5:0]  nb;
      logic        oe;
      logic [7:0]  exp;
   } row_t;

   localparam int NROWS = 45;

   logic       clk = 1'h0;
   logic       srst = 1'h1;
   logic       wp_n = 1'h1;
   logic       cs_n, sck, si, so, so_oe_n, drove;
   logic [7:0] rx;
   int         failures = 0;
   int         num_checks = 0;

   // -------------------------------------------------------------------------
   // Frames: write protect level, command bits, bit count, expected reply.
   // -------------------------------------------------------------------------
   row_t rows [NROWS] = '{
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h1, 8'h00},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h1, 8'h02},
      '{1'h1, 40'h02_7FFF_6677, 6'd40, 1'h0, 8'h00},
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h1, 8'h00},
      '{1'h1, 40'h03_0000_0000, 6'd32, 1'h1, 8'h77},
      '{1'h1, 40'h0B_0000_0000, 6'd40, 1'h1, 8'h77},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h0, 40'h02_6000_5500, 6'd32, 1'h0, 8'h00},
      '{1'h1, 40'h03_E000_0000, 6'd32, 1'h1, 8'h55},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h04_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h1, 8'h00},
      '{1'h1, 40'h02_6000_AB00, 6'd32, 1'h0, 8'h00},
      '{1'h1, 40'h03_6000_0000, 6'd32, 1'h1, 8'h55},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h01_F700_0000, 6'd16, 1'h0, 8'h00},
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h1, 8'h84},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h02_5FFF_3344, 6'd40, 1'h0, 8'h00},
      '{1'h1, 40'h03_5FFF_0000, 6'd40, 1'h1, 8'h55},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h0, 40'h01_0000_0000, 6'd16, 1'h0, 8'h00},
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h1, 8'h84},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h01_8800_0000, 6'd16, 1'h0, 8'h00},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h02_5FFF_CC00, 6'd32, 1'h0, 8'h00},
      '{1'h1, 40'h03_5FFF_0000, 6'd32, 1'h1, 8'h33},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h01_8C00_0000, 6'd16, 1'h0, 8'h00},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h02_0000_CC00, 6'd32, 1'h0, 8'h00},
      '{1'h1, 40'h03_0000_0000, 6'd32, 1'h1, 8'h77},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h01_0000_0000, 6'd16, 1'h0, 8'h00},
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h1, 8'h00},
      '{1'h1, 40'h06_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h02_7FFE_1200, 6'd36, 1'h0, 8'h00},
      '{1'h1, 40'h03_7FFE_0000, 6'd40, 1'h1, 8'h66},
      '{1'h1, 40'h9F_0000_0000, 6'd16, 1'h1, ID_FILL},
      '{1'h1, 40'hB9_0000_0000, 6'd8,  1'h0, 8'h00},
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h0, 8'h00},
      '{1'h1, 40'h05_0000_0000, 6'd16, 1'h1, 8'h00},
      '{1'h1, 40'hFF_0500_0000, 6'd24, 1'h0, 8'h00}
   };

   always #20 clk = ~clk;

   spi_fram_command_core i_spi_fram_command_core (
      .CLK(clk), .SRST(srst), .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
      .SO(so), .SO_OE_N(so_oe_n));

   spi_master_model i_spi_master_model (
      .clk(clk), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n), .sck(sck), .si(si));

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // -------------------------------------------------------------------------
   // Main sequence.
   // -------------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'h0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < NROWS; i++) begin
         wp_n <= rows[i].wp;
         @(posedge clk);
         i_spi_master_model.frame(1'h0, rows[i].bits, int'(rows[i].nb), rx, drove);
         check({drove, drove ? rx : 8'h00}, {rows[i].oe, rows[i].exp});
         check({so_oe_n, 8'h00}, 9'h100);
         $display("row %0d done", i);
      end
      // Mode 3 selected by a high clock at select; a reset mid-run drops the latch.
      i_spi_master_model.frame(1'h1, 40'h06_0000_0000, 8, rx, drove);
      i_spi_master_model.frame(1'h1, 40'h05_0000_0000, 16, rx, drove);
      check({drove, rx}, 9'h102);
      srst <= 1'h1;
      repeat (16) @(posedge clk);
      srst <= 1'h0;
      repeat (4) @(posedge clk);
      i_spi_master_model.frame(1'h0, 40'h05_0000_0000, 16, rx, drove);
      check({drove, rx}, 9'h100);
      $display("mode and reset test done");
      final_report();
   end
endmodule // testbench
